/* File: verilog/csd_pkg.sv */
// Purpose: Constants and types of the core status datapath
// Assumes: APB slave, 32-bit data, byte addresses
// Notes: Register offsets, status bit positions and command fields
package csd_pkg;
    // Register byte offsets
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_CTRL = 8'h04;
    localparam logic [7:0] ADDR_OPA = 8'h08;
    localparam logic [7:0] ADDR_OPB = 8'h0c;
    localparam logic [7:0] ADDR_CMD = 8'h10;
    localparam logic [7:0] ADDR_RES_LO = 8'h14;
    localparam logic [7:0] ADDR_RES_HI = 8'h18;
    localparam logic [7:0] ADDR_PC = 8'h1c;
    localparam logic [7:0] ADDR_PAGE = 8'h20;
    localparam logic [7:0] ADDR_XMOD = 8'h24;
    localparam logic [7:0] ADDR_YMOD = 8'h28;
    localparam logic [7:0] ADDR_ACCA = 8'h2c;
    localparam logic [7:0] ADDR_ACCB = 8'h30;
    localparam logic [1:0] WREG_WINDOW = 2'h1;
    // Status bit positions
    localparam int ST_OA = 15;
    localparam int ST_OB = 14;
    localparam int ST_SA = 13;
    localparam int ST_SB = 12;
    localparam int ST_SAB = 10;
    localparam int ST_DC = 8;
    localparam int ST_IPL = 5;
    localparam int ST_N = 3;
    localparam int ST_OV = 2;
    localparam int ST_Z = 1;
    localparam int ST_C = 0;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    // Control bit positions
    localparam int CT_PRIO_MSB = 0;
    localparam int CT_NEST_DIS = 1;
    localparam int CT_PSV_EN = 2;
    localparam int CT_SAT_EN = 3;
    localparam int CT_XMOD_EN = 4;
    localparam int CT_YMOD_EN = 5;
    // Command fields
    localparam int CM_BYTE = 4;
    localparam int CM_A_SIGNED = 5;
    localparam int CM_B_SIGNED = 6;
    localparam int CM_ACC_B = 7;
    localparam int CM_SHAMT = 8;
    localparam int CM_LEFT = 13;
    localparam int CM_LONG = 14;
    // Timing, steps and limits
    localparam logic [4:0] DIV_CYCLES = 5'h13;
    localparam logic [4:0] DIV_STEP_HI = 5'h12;
    localparam logic [4:0] DIV_STEP_LO = 5'h03;
    localparam logic [4:0] SHIFT_MAX = 5'h10;
    localparam logic [22:0] PC_STEP = 23'h00_0002;
    localparam logic [15:0] STACK_FRAME = 16'h0004;
    localparam logic [15:0] WORD_STEP = 16'h0002;
    localparam logic [39:0] SAT_POS = 40'h00_7fff_ffff;
    localparam logic [39:0] SAT_NEG = 40'hff_8000_0000;

    typedef enum logic [3:0] {
        OP_ADD = 4'h0,
        OP_SUB = 4'h1,
        OP_MUL = 4'h2,
        OP_MAC = 4'h3,
        OP_SHIFT = 4'h4,
        OP_DIV = 4'h5,
        OP_AGX = 4'h6,
        OP_AGY = 4'h7,
        OP_BREV = 4'h8,
        OP_REPEAT = 4'h9,
        OP_DO = 4'ha,
        OP_NOP = 4'hf
    } csd_op_t;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_DIV = 1'b1
    } csd_fsm_t;

    typedef struct packed {
        logic [15:0][15:0] wreg;
        logic [22:0] pc;
        logic [23:0] instr;
        logic [31:0] opa;
        logic [31:0] opb;
        logic [31:0] res_lo;
        logic [31:0] res_hi;
        logic [39:0] acca;
        logic [39:0] accb;
        logic oa;
        logic ob;
        logic sa;
        logic sb;
        logic dc;
        logic n;
        logic ov;
        logic z;
        logic c;
        logic [2:0] ipl;
        logic [5:0] ctrl;
        logic [7:0] page;
        logic [31:0] xmod;
        logic [31:0] ymod;
        logic [15:0] rpt_cnt;
        logic [15:0] do_cnt;
        logic ra;
        logic da;
        csd_fsm_t fsm;
        logic [4:0] div_cnt;
        logic [15:0] rem;
        logic [15:0] quo;
        logic [15:0] dvs;
        logic [15:0] dvd_lo;
        logic q_neg;
        logic r_neg;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic irq_take;
        logic user_irq_off;
    } csd_state_t;
endpackage

/* File: verilog/csd_core.sv */
// Purpose: Core status datapath: ALU flags, multiplier, shifter, divider,
//          address generators, program window, loops and status register
// Assumes: APB slave on mclk_in; interrupt request comes from logic on mclk_in
// Notes: Commands are written to the command register and run at once
module csd_core (
    input wire logic mclk_in,
    input wire logic arst_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic irq_req_in,
    input wire logic [2:0] irq_level_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    output logic irq_take_out,
    output logic user_irq_off_out
);
    csd_pkg::csd_state_t s_r;
    csd_pkg::csd_state_t s_nxt;
    logic [15:0] brev_a;
    logic [15:0] brev_b;
    logic [15:0] brev_sum;
    logic [15:0] brev_ea;

    // Bit reversal of the index and step for reversed-carry addressing
    assign brev_sum = brev_a + brev_b;
    for (genvar i = 0; i < 16; i++) begin : g_brev
        assign brev_a[i] = s_r.opa[15 - i];
        assign brev_b[i] = s_r.opb[15 - i];
        assign brev_ea[i] = brev_sum[15 - i];
    end

    // Next-state logic for the whole block
    always_comb begin
        logic access;
        logic [15:0] status;
        logic [3:0] op;
        logic [15:0] a16;
        logic [15:0] b16;
        logic cin;
        logic [16:0] sum17;
        logic [8:0] sum9;
        logic [4:0] sum5;
        logic [16:0] a17;
        logic [16:0] b17;
        logic [33:0] prod;
        logic [39:0] sh_in;
        logic [39:0] sh_out;
        logic [4:0] shamt;
        logic [39:0] acc;
        logic [39:0] acc_sum;
        logic acc_ovf;
        logic [15:0] ea;
        logic [31:0] mreg;
        logic [31:0] dvd;
        logic [31:0] dvd_mag;
        logic [16:0] trial;
        logic wr_ok;

        s_nxt = s_r;
        access = psel_in & penable_in & ~s_r.pready;
        op = pwdata_in[3:0];
        status = {s_r.oa, s_r.ob, s_r.sa, s_r.sb, s_r.oa | s_r.ob,
                  s_r.sa | s_r.sb, s_r.da, s_r.dc, s_r.ipl, s_r.ra,
                  s_r.n, s_r.ov, s_r.z, s_r.c};
        a16 = s_r.opa[15:0];
        b16 = s_r.opb[15:0];
        cin = 1'b0;
        sum17 = '0;
        sum9 = '0;
        sum5 = '0;
        a17 = '0;
        b17 = '0;
        prod = '0;
        sh_in = '0;
        sh_out = '0;
        shamt = '0;
        acc = '0;
        acc_sum = '0;
        acc_ovf = 1'b0;
        ea = '0;
        mreg = '0;
        dvd = '0;
        dvd_mag = '0;
        trial = '0;
        wr_ok = 1'b0;
        s_nxt.irq_take = 1'b0;

        // Loop counters run beside other operations; the repeat counter holds while the divider runs
        if (s_r.ra && s_r.fsm == csd_pkg::ST_IDLE) begin
            if (s_r.rpt_cnt == 16'h0000) begin
                s_nxt.ra = 1'b0;
            end else begin
                s_nxt.rpt_cnt = s_r.rpt_cnt - 16'h0001;
            end
        end

        if (s_r.da) begin
            if (s_r.do_cnt == 16'h0000) begin
                s_nxt.da = 1'b0;
            end else begin
                s_nxt.do_cnt = s_r.do_cnt - 16'h0001;
            end
        end

        // Interrupt acceptance never disturbs loop or divide state
        if (irq_req_in && !s_r.ctrl[csd_pkg::CT_PRIO_MSB] && !s_r.irq_take &&
            irq_level_in > s_r.ipl) begin
            s_nxt.irq_take = 1'b1;
            s_nxt.wreg[15] = s_r.wreg[15] + csd_pkg::STACK_FRAME;
        end

        // Iterative divide, one quotient bit per cycle
        if (s_r.fsm == csd_pkg::ST_DIV) begin
            s_nxt.div_cnt = s_r.div_cnt - 5'h01;
            if (s_r.div_cnt <= csd_pkg::DIV_STEP_HI && s_r.div_cnt >= csd_pkg::DIV_STEP_LO) begin
                trial = {s_r.rem, s_r.dvd_lo[15]};
                s_nxt.dvd_lo = {s_r.dvd_lo[14:0], 1'b0};
                if (trial >= {1'b0, s_r.dvs}) begin
                    trial = trial - {1'b0, s_r.dvs};
                    s_nxt.quo = {s_r.quo[14:0], 1'b1};
                end else begin
                    s_nxt.quo = {s_r.quo[14:0], 1'b0};
                end
                s_nxt.rem = trial[15:0];
            end

            if (s_r.div_cnt == 5'h01) begin
                s_nxt.fsm = csd_pkg::ST_IDLE;
                s_nxt.ra = 1'b0;
                s_nxt.wreg[0] = s_r.q_neg ? 16'h0000 - s_r.quo : s_r.quo;
                s_nxt.wreg[1] = s_r.r_neg ? 16'h0000 - s_r.rem : s_r.rem;
                s_nxt.res_lo = {16'h0000, s_nxt.wreg[0]};
                s_nxt.res_hi = {16'h0000, s_nxt.wreg[1]};
            end
        end

        // APB access phase: answer one cycle after it opens
        s_nxt.pready = access;
        s_nxt.pslverr = 1'b0;
        if (access) begin
            wr_ok = 1'b1;
            unique case (paddr_in)
                csd_pkg::ADDR_STATUS: s_nxt.prdata = {16'h0000, status};
                csd_pkg::ADDR_CTRL: s_nxt.prdata = {26'h000_0000, s_r.ctrl};
                csd_pkg::ADDR_OPA: s_nxt.prdata = s_r.opa;
                csd_pkg::ADDR_OPB: s_nxt.prdata = s_r.opb;
                csd_pkg::ADDR_CMD: s_nxt.prdata = {8'h00, s_r.instr};
                csd_pkg::ADDR_RES_LO: s_nxt.prdata = s_r.res_lo;
                csd_pkg::ADDR_RES_HI: s_nxt.prdata = s_r.res_hi;
                csd_pkg::ADDR_PC: s_nxt.prdata = {9'h000, s_r.pc};
                csd_pkg::ADDR_PAGE: s_nxt.prdata = {24'h00_0000, s_r.page};
                csd_pkg::ADDR_XMOD: s_nxt.prdata = s_r.xmod;
                csd_pkg::ADDR_YMOD: s_nxt.prdata = s_r.ymod;
                csd_pkg::ADDR_ACCA: s_nxt.prdata = s_r.acca[31:0];
                csd_pkg::ADDR_ACCB: s_nxt.prdata = s_r.accb[31:0];
                default: begin
                    if (paddr_in[7:6] == csd_pkg::WREG_WINDOW && paddr_in[1:0] == 2'h0) begin
                        s_nxt.prdata = {16'h0000, s_r.wreg[paddr_in[5:2]]};
                    end else begin
                        s_nxt.prdata = 32'h0000_0000;
                        s_nxt.pslverr = 1'b1;
                        wr_ok = 1'b0;
                    end
                end
            endcase

            // A command while the divider runs is refused
            if (paddr_in == csd_pkg::ADDR_CMD && pwrite_in &&
                s_r.fsm == csd_pkg::ST_DIV) begin
                s_nxt.pslverr = 1'b1;
                wr_ok = 1'b0;
            end
        end

        // Register writes; hardware flag sets below take precedence
        if (wr_ok && pwrite_in) begin
            unique case (paddr_in)
                csd_pkg::ADDR_STATUS: begin
                    s_nxt.sa = s_r.sa & pwdata_in[csd_pkg::ST_SA] & pwdata_in[csd_pkg::ST_SAB];
                    s_nxt.sb = s_r.sb & pwdata_in[csd_pkg::ST_SB] & pwdata_in[csd_pkg::ST_SAB];
                    s_nxt.dc = pwdata_in[csd_pkg::ST_DC];
                    s_nxt.n = pwdata_in[csd_pkg::ST_N];
                    s_nxt.ov = pwdata_in[csd_pkg::ST_OV];
                    s_nxt.z = pwdata_in[csd_pkg::ST_Z];
                    s_nxt.c = pwdata_in[csd_pkg::ST_C];
                    if (!s_r.ctrl[csd_pkg::CT_NEST_DIS]) begin
                        s_nxt.ipl = pwdata_in[csd_pkg::ST_IPL +: 3];
                    end
                end
                csd_pkg::ADDR_CTRL: s_nxt.ctrl = pwdata_in[5:0];
                csd_pkg::ADDR_OPA: s_nxt.opa = pwdata_in;
                csd_pkg::ADDR_OPB: s_nxt.opb = pwdata_in;
                csd_pkg::ADDR_PC: s_nxt.pc = pwdata_in[22:0];
                csd_pkg::ADDR_PAGE: s_nxt.page = pwdata_in[7:0];
                csd_pkg::ADDR_XMOD: s_nxt.xmod = pwdata_in;
                csd_pkg::ADDR_YMOD: s_nxt.ymod = pwdata_in;
                csd_pkg::ADDR_CMD: s_nxt.instr = pwdata_in[23:0];
                default: begin
                    if (paddr_in[7:6] == csd_pkg::WREG_WINDOW) begin
                        s_nxt.wreg[paddr_in[5:2]] = pwdata_in[15:0];
                    end
                end
            endcase
        end

        // Command execution: every operation but divide ends in one cycle
        if (wr_ok && pwrite_in && paddr_in == csd_pkg::ADDR_CMD) begin
            s_nxt.pc = s_r.pc + csd_pkg::PC_STEP;
            unique case (op)
                csd_pkg::OP_ADD, csd_pkg::OP_SUB: begin
                    if (op == csd_pkg::OP_SUB) begin
                        b16 = ~b16;
                        cin = 1'b1;
                    end
                    sum17 = {1'b0, a16} + {1'b0, b16} + {16'h0000, cin};
                    sum9 = {1'b0, a16[7:0]} + {1'b0, b16[7:0]} + {8'h00, cin};
                    sum5 = {1'b0, a16[3:0]} + {1'b0, b16[3:0]} + {4'h0, cin};
                    s_nxt.res_lo = {16'h0000, sum17[15:0]};
                    if (pwdata_in[csd_pkg::CM_BYTE]) begin
                        s_nxt.dc = sum5[4];
                        s_nxt.c = sum9[8];
                        s_nxt.n = sum9[7];
                        s_nxt.z = sum9[7:0] == 8'h00;
                        s_nxt.ov = (a16[7] == b16[7]) && (sum9[7] != a16[7]);
                    end else begin
                        s_nxt.dc = sum9[8];
                        s_nxt.c = sum17[16];
                        s_nxt.n = sum17[15];
                        s_nxt.z = sum17[15:0] == 16'h0000;
                        s_nxt.ov = (a16[15] == b16[15]) && (sum17[15] != a16[15]);
                    end
                end

                csd_pkg::OP_MUL, csd_pkg::OP_MAC: begin
                    a17 = {pwdata_in[csd_pkg::CM_A_SIGNED] & a16[15], a16};
                    b17 = {pwdata_in[csd_pkg::CM_B_SIGNED] & b16[15], b16};
                    prod = 34'($signed(a17) * $signed(b17));
                    s_nxt.res_lo = prod[31:0];
                    s_nxt.res_hi = {30'h0000_0000, prod[33:32]};
                    if (op == csd_pkg::OP_MAC) begin
                        acc = pwdata_in[csd_pkg::CM_ACC_B] ? s_r.accb : s_r.acca;
                        acc_sum = acc + {{6{prod[33]}}, prod};
                        acc_ovf = ~(&acc_sum[39:31] | ~|acc_sum[39:31]);
                        if (acc_ovf && s_r.ctrl[csd_pkg::CT_SAT_EN]) begin
                            acc_sum = acc_sum[39] ? csd_pkg::SAT_NEG : csd_pkg::SAT_POS;
                        end
                        if (pwdata_in[csd_pkg::CM_ACC_B]) begin
                            s_nxt.accb = acc_sum;
                            s_nxt.ob = acc_ovf & ~s_r.ctrl[csd_pkg::CT_SAT_EN];
                            s_nxt.sb = s_nxt.sb | (acc_ovf & s_r.ctrl[csd_pkg::CT_SAT_EN]);
                        end else begin
                            s_nxt.acca = acc_sum;
                            s_nxt.oa = acc_ovf & ~s_r.ctrl[csd_pkg::CT_SAT_EN];
                            s_nxt.sa = s_nxt.sa | (acc_ovf & s_r.ctrl[csd_pkg::CT_SAT_EN]);
                        end
                    end
                end

                csd_pkg::OP_SHIFT: begin
                    sh_in = {s_r.opb[7:0], s_r.opa};
                    shamt = pwdata_in[csd_pkg::CM_SHAMT +: 5];
                    if (shamt > csd_pkg::SHIFT_MAX) begin
                        shamt = csd_pkg::SHIFT_MAX;
                    end
                    if (pwdata_in[csd_pkg::CM_LEFT]) begin
                        sh_out = sh_in << shamt;
                    end else begin
                        sh_out = $signed(sh_in) >>> shamt;
                    end
                    s_nxt.res_lo = sh_out[31:0];
                    s_nxt.res_hi = {24'h00_0000, sh_out[39:32]};
                end

                csd_pkg::OP_DIV: begin
                    if (pwdata_in[csd_pkg::CM_LONG]) begin
                        dvd = s_r.opa;
                    end else if (pwdata_in[csd_pkg::CM_A_SIGNED]) begin
                        dvd = {{16{a16[15]}}, a16};
                    end else begin
                        dvd = {16'h0000, a16};
                    end
                    dvd_mag = (pwdata_in[csd_pkg::CM_A_SIGNED] && dvd[31]) ? 32'h0000_0000 - dvd : dvd;
                    s_nxt.dvs = (pwdata_in[csd_pkg::CM_A_SIGNED] && b16[15]) ? 16'h0000 - b16 : b16;
                    s_nxt.q_neg = pwdata_in[csd_pkg::CM_A_SIGNED] & (dvd[31] ^ b16[15]);
                    s_nxt.r_neg = pwdata_in[csd_pkg::CM_A_SIGNED] & dvd[31];
                    s_nxt.rem = dvd_mag[31:16];
                    s_nxt.dvd_lo = dvd_mag[15:0];
                    s_nxt.quo = 16'h0000;
                    s_nxt.div_cnt = csd_pkg::DIV_CYCLES;
                    s_nxt.fsm = csd_pkg::ST_DIV;
                    s_nxt.ra = 1'b1;
                    s_nxt.rpt_cnt = 16'h0000;
                end

                csd_pkg::OP_AGX, csd_pkg::OP_AGY: begin
                    ea = a16 + b16;
                    mreg = (op == csd_pkg::OP_AGX) ? s_r.xmod : s_r.ymod;
                    if (ea > mreg[31:16] && ((op == csd_pkg::OP_AGX) ?
                        s_r.ctrl[csd_pkg::CT_XMOD_EN] : s_r.ctrl[csd_pkg::CT_YMOD_EN])) begin
                        ea = ea - mreg[31:16] + mreg[15:0] - csd_pkg::WORD_STEP;
                    end
                    s_nxt.res_lo = {16'h0000, ea};
                    s_nxt.res_hi = 32'h0000_0000;
                    if (op == csd_pkg::OP_AGX && ea[15] && s_r.ctrl[csd_pkg::CT_PSV_EN]) begin
                        s_nxt.res_hi = {9'h000, s_r.page, ea[14:0]};
                    end
                end

                csd_pkg::OP_BREV: s_nxt.res_lo = {16'h0000, brev_ea};

                csd_pkg::OP_REPEAT: begin
                    s_nxt.rpt_cnt = a16;
                    s_nxt.ra = 1'b1;
                end
                csd_pkg::OP_DO: begin
                    s_nxt.do_cnt = a16;
                    s_nxt.da = 1'b1;
                end
                default: s_nxt.res_lo = s_r.res_lo;
            endcase
        end

        s_nxt.user_irq_off = s_nxt.ctrl[csd_pkg::CT_PRIO_MSB];
    end

    // State register
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from state flops
    assign prdata_out = s_r.prdata;
    assign pready_out = s_r.pready;
    assign pslverr_out = s_r.pslverr;
    assign irq_take_out = s_r.irq_take;
    assign user_irq_off_out = s_r.user_irq_off;
endmodule

/* File: verification/csd_core_checker.sv */
// Purpose: Port checks of the core status datapath
// Assumes: One clock, asynchronous active-low reset
// Notes: Bound to every csd_core instance
module csd_core_checker (
    input wire logic mclk_in,
    input wire logic arst_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic irq_req_in,
    input wire logic [2:0] irq_level_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic irq_take_out,
    input wire logic user_irq_off_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!arst_n_in);
    logic ctl_wr;
    // Control write taken at this edge
    assign ctl_wr = psel_in && penable_in && pwrite_in && !pready_out
        && paddr_in == csd_pkg::ADDR_CTRL;
    // Bus answer timing
    a_ready_wait: assert property (psel_in && penable_in && !pready_out |=> pready_out)
        else $error("no ready after access");
    a_ready_pulse: assert property (pready_out |=> !pready_out)
        else $error("ready longer than one cycle");
    a_idle_quiet: assert property (!psel_in |=> !pready_out)
        else $error("ready without access");
    a_err_ready: assert property (pslverr_out |-> pready_out)
        else $error("error without ready");
    // Priority MSB copy and interrupt acceptance
    a_off_tracks: assert property (ctl_wr |=> user_irq_off_out == $past(pwdata_in[0]))
        else $error("interrupt disable not updated");
    a_off_stable: assert property (!ctl_wr |=> $stable(user_irq_off_out))
        else $error("interrupt disable changed alone");
    a_off_blocks: assert property (user_irq_off_out |=> !irq_take_out)
        else $error("interrupt taken while disabled");
    a_take_cause: assert property (irq_take_out |-> $past(irq_req_in) && $past(irq_level_in) != 3'h0)
        else $error("interrupt taken without cause");
    a_take_pulse: assert property (irq_take_out |=> !irq_take_out)
        else $error("take longer than one cycle");
endmodule
bind csd_core csd_core_checker u_csd_core_checker (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .irq_req_in(irq_req_in), .irq_level_in(irq_level_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .irq_take_out(irq_take_out), .user_irq_off_out(user_irq_off_out));

/* File: verification/csd_core_tb_top.sv */
// Purpose: Self-checking bench of the core status datapath
// Assumes: APB master driving right after the rising edge
// Notes: Driver queues expected answers, a monitor checks them
module csd_core_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} csd_note_t;
    csd_note_t q[$];
    int iq[$];
    int failures = 0;
    int n_compared = 0;
    int nirq = 0;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic sel = 1'b0;
    logic en = 1'b0;
    logic wr = 1'b0;
    logic irq = 1'b0;
    logic [2:0] lvl = 3'h0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wd = 32'h0000_0000;
    logic [31:0] lf = 32'h0000_2e01;
    logic [31:0] rdat;
    logic rdy, err, take, off;
    always #2 clk = ~clk;
    csd_core u_csd_core (.mclk_in(clk), .arst_n_in(rst_n), .psel_in(sel), .penable_in(en),
        .pwrite_in(wr), .paddr_in(addr), .pwdata_in(wd), .irq_req_in(irq),
        .irq_level_in(lvl), .prdata_out(rdat), .pready_out(rdy), .pslverr_out(err),
        .irq_take_out(take), .user_irq_off_out(off));
    function automatic logic [31:0] nx(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // One APB transfer; the expected answer is queued first
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [31:0] ex, input logic [31:0] m, input logic e);
        q.push_back('{ex, m, e});
        sel <= 1'b1;
        wr <= w;
        addr <= a;
        wd <= d;
        @(posedge clk);
        en <= 1'b1;
        do @(posedge clk); while (!rdy);
        sel <= 1'b0;
        en <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic [31:0] m);
        xfer(1'b0, a, 32'h0000_0000, ex, m, 1'b0);
    endtask
    task automatic wt(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 32'h0000_0000, 32'h0000_0000, 1'b0);
    endtask
    task automatic op(input logic [31:0] c, input logic [31:0] a, input logic [31:0] b);
        wt(csd_pkg::ADDR_OPA, a);
        wt(csd_pkg::ADDR_OPB, b);
        wt(csd_pkg::ADDR_CMD, c);
    endtask
    // Answers and interrupt takes are matched to the oldest note
    always @(negedge clk) begin
        if (rdy) begin
            cmp({31'h0, q.size() != 0}, 32'h0000_0001);
            cmp(rdat & q[0].m, q[0].d);
            cmp({31'h0, err}, {31'h0, q[0].e});
            void'(q.pop_front());
        end
        if (take) cmp({31'h0, iq.size() != 0}, 32'h0000_0001);
        if (take && iq.size() != 0) void'(iq.pop_front());
    end
    // Watchdog
    initial begin
        #20000;
        failures++;
        end_of_test();
    end
    initial begin
        logic [16:0] t;
        logic [8:0] u;
        logic s;
        int i;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(csd_pkg::ADDR_STATUS, 32'h0000_0000, 32'h0000_ffff);
        wt(csd_pkg::ADDR_PC, 32'hffff_ffff);
        rd(csd_pkg::ADDR_PC, 32'h007f_ffff, 32'hffff_ffff);
        wt(csd_pkg::ADDR_PC, 32'h0000_0000);
        wt(csd_pkg::ADDR_STATUS, 32'h0000_ffff);
        rd(csd_pkg::ADDR_STATUS, 32'h0000_01ef, 32'h0000_ffff);
        wt(csd_pkg::ADDR_STATUS, 32'h0000_0000);
        wt(csd_pkg::ADDR_CTRL, 32'h0000_0002);
        wt(csd_pkg::ADDR_STATUS, 32'h0000_00e0);
        rd(csd_pkg::ADDR_STATUS, 32'h0000_0000, 32'h0000_00e0);
        wt(csd_pkg::ADDR_CTRL, 32'h0000_0000);
        $display("test status bits done");
        // Random add and subtract: result and flags
        for (i = 0; i < 8; i++) begin
            lf = nx(lf);
            s = i[0];
            t = s ? {1'b0, lf[15:0]} - {1'b0, lf[31:16]} : {1'b0, lf[15:0]} + {1'b0, lf[31:16]};
            u = s ? {1'b0, lf[7:0]} - {1'b0, lf[23:16]} : {1'b0, lf[7:0]} + {1'b0, lf[23:16]};
            op({31'h0, s}, {16'h0, lf[15:0]}, {16'h0, lf[31:16]});
            rd(csd_pkg::ADDR_RES_LO, {16'h0, t[15:0]}, 32'h0000_ffff);
            rd(csd_pkg::ADDR_STATUS, {23'h0, u[8] ^ s, 4'h0, t[15],
                (lf[15] ^ lf[31]) == s && t[15] != lf[15], t[15:0] == 16'h0,
                t[16] ^ s}, 32'h0000_010f);
        end
        rd(csd_pkg::ADDR_PC, 32'h0000_0010, 32'hffff_ffff);
        op(32'h0000_0062, 32'h0000_ffff, 32'h0000_ffff);
        rd(csd_pkg::ADDR_RES_LO, 32'h0000_0001, 32'hffff_ffff);
        op(32'h0000_0022, 32'h0000_ffff, 32'h0000_ffff);
        rd(csd_pkg::ADDR_RES_LO, 32'hffff_0001, 32'hffff_ffff);
        op(32'h0000_1404, 32'h1234_5678, 32'h0000_0080);
        rd(csd_pkg::ADDR_RES_LO, 32'hff80_1234, 32'hffff_ffff);
        // Saturating then overflowing accumulation into A
        wt(csd_pkg::ADDR_CTRL, 32'h0000_0008);
        for (i = 0; i < 3; i++) op(32'h0000_0063, 32'h0000_7fff, 32'h0000_7fff);
        rd(csd_pkg::ADDR_ACCA, 32'h7fff_ffff, 32'hffff_ffff);
        rd(csd_pkg::ADDR_STATUS, 32'h0000_2400, 32'h0000_fc00);
        wt(csd_pkg::ADDR_STATUS, 32'h0000_0000);
        rd(csd_pkg::ADDR_STATUS, 32'h0000_0000, 32'h0000_3400);
        wt(csd_pkg::ADDR_CTRL, 32'h0000_0000);
        op(32'h0000_0063, 32'h0000_7fff, 32'h0000_7fff);
        wt(csd_pkg::ADDR_STATUS, 32'h0000_0000);
        rd(csd_pkg::ADDR_STATUS, 32'h0000_8800, 32'h0000_c800);
        $display("test arithmetic done");
        op(32'h0000_0005, 32'h0000_0064, 32'h0000_0007);
        xfer(1'b1, csd_pkg::ADDR_CMD, 32'h0000_000f, 32'h0, 32'h0, 1'b1);
        rd(csd_pkg::ADDR_STATUS, 32'h0000_0010, 32'h0000_0010);
        repeat (19) @(posedge clk);
        rd(8'h40, 32'h0000_000e, 32'h0000_ffff);
        rd(8'h44, 32'h0000_0002, 32'h0000_ffff);
        // Modulo wrap in X then Y, window page, reversed carry
        for (i = 0; i < 2; i++) begin
            wt(csd_pkg::ADDR_XMOD + 8'(i * 4), 32'h1010_1000);
            wt(csd_pkg::ADDR_CTRL, 32'h0000_0010 << i);
            op(32'h0000_0006 + i, 32'h0000_100e, 32'h0000_0004);
            rd(csd_pkg::ADDR_RES_LO, 32'h0000_1000, 32'h0000_ffff);
        end
        wt(csd_pkg::ADDR_PAGE, 32'h0000_005a);
        wt(csd_pkg::ADDR_CTRL, 32'h0000_0004);
        op(32'h0000_0006, 32'h0000_8000, 32'h0000_0004);
        rd(csd_pkg::ADDR_RES_HI, 32'h002d_0004, 32'h007f_ffff);
        op(32'h0000_0008, 32'h0000_0008, 32'h0000_0008);
        rd(csd_pkg::ADDR_RES_LO, 32'h0000_0004, 32'h0000_ffff);
        xfer(1'b0, 8'h34, 32'h0, 32'h0, 32'hffff_ffff, 1'b1);
        op(32'h0000_0009, 32'h0000_0010, 32'h0000_0000);
        rd(csd_pkg::ADDR_STATUS, 32'h0000_0010, 32'h0000_0010);
        op(32'h0000_000a, 32'h0000_0010, 32'h0000_0000);
        rd(csd_pkg::ADDR_STATUS, 32'h0000_0200, 32'h0000_0200);
        $display("test addressing and loops done");
        // Random priority, mask and request level
        for (i = 0; i < 8; i++) begin
            lf = nx(lf);
            wt(csd_pkg::ADDR_STATUS, {24'h0, lf[2:0] & {3{i[0]}}, 5'h0});
            wt(csd_pkg::ADDR_CTRL, {31'h0, lf[3] & i[0]});
            cmp({31'h0, off}, {31'h0, lf[3] & i[0]});
            if (lf[6:4] > (lf[2:0] & {3{i[0]}}) && !(lf[3] & i[0])) iq.push_back(1);
            nirq += lf[6:4] > (lf[2:0] & {3{i[0]}}) && !(lf[3] & i[0]);
            lvl <= lf[6:4];
            irq <= 1'b1;
            @(posedge clk);
            irq <= 1'b0;
            repeat (3) @(posedge clk);
        end
        rd(8'h7c, 32'(nirq * 4), 32'h0000_ffff);
        cmp(32'(iq.size()), 32'h0000_0000);
        $display("test interrupts done");
        end_of_test();
    end
endmodule
